// ===== verilog/spci_pkg.sv
// Shared constants for the slave port command interface
package spci_pkg;
    // Master-visible register selects
    localparam logic [1:0] SPCI_SEL_CMD    = 2'h0;
    localparam logic [1:0] SPCI_SEL_CHAN   = 2'h1;
    localparam logic [1:0] SPCI_SEL_DATA   = 2'h2;
    localparam logic [1:0] SPCI_SEL_STATUS = 2'h3;
    // Internal register locations
    localparam logic [7:0] SPCI_LOC_CMD    = 8'h20;
    localparam logic [7:0] SPCI_LOC_CHAN   = 8'h21;
    localparam logic [7:0] SPCI_LOC_DATA   = 8'h22;
    localparam logic [7:0] SPCI_LOC_STATUS = 8'h23;
    // Status bit positions
    localparam int SPCI_ST_CMD  = 0;
    localparam int SPCI_ST_CHAN = 1;
    localparam int SPCI_ST_DATA = 2;
    localparam int SPCI_ST_RESP = 3;
    // Reset value and value read at the unused address
    localparam logic [7:0] SPCI_BYTE_RST = 8'h00;
    localparam logic [7:0] SPCI_UNUSED_RD = 8'h00;
endpackage

// ===== verilog/spci_port.sv
// Slave port command interface: master-side parallel port and slave-side access
`timescale 1ns/1ps
// Operation
// (R1) Master starts all; one response per command
// (R2) Master loads channel and data before command
// (R3) Slave writes response; attention goes low
// (R4) Master reads results, then writes status
// (R5) Four addresses map to locations 0x20-0x23
// (R6) Addresses 0-2 split read and write registers
// (R7) Address 0: command in, response out
// (R8) Address 1 write sets channel; read undefined
// (R9) Address 2: data in, returned data out
// (R10) Address 3 read returns update status bits
// (R11) Response write sets status bit 3
// (R12) Any status write clears bit 3
// (R13) Attention held until master status write
// (R14) Master reads response before next command
// (R15) Access only while select is low
// (R16) Write strobe writes, read strobe reads
// (R17) Two select lines decode four addresses
// (R18) Full channel byte reaches slave logic
// (R19) Command write raises event and poll flag
// (R20) Master polls bit 3 or uses attention
// (R21) Data bus driven only in selected read
// (R22) Slave flags set on write, clear on read
module spci_port
    import spci_pkg::*;
(
    input  wire logic       CLOCK_I,
    input  wire logic       RST_I,
    // Master side
    input  wire logic       SELECT_N_I,
    input  wire logic       WRITE_STROBE_N_I,
    input  wire logic       READ_STROBE_N_I,
    input  wire logic       REG_SEL_LO_I,
    input  wire logic       REG_SEL_HI_I,
    input  wire logic [7:0] DATA_I,
    output logic      [7:0] DATA_O,
    output logic            DATA_OE_N_O,
    output logic            ATTENTION_OUT_N_O,
    // Slave side
    input  wire logic       SLV_RD_I,
    input  wire logic [7:0] SLV_ADDR_I,
    output logic      [7:0] SLV_RDATA_O,
    input  wire logic       SLV_WR_I,
    input  wire logic [7:0] SLV_WDATA_I,
    output logic            CMD_EVENT_O,
    output logic            CMD_PENDING_O,
    output logic            CHAN_PENDING_O,
    output logic            DATA_PENDING_O
);

    // ----------------------------------------------------------------
    // Master access decode
    // ----------------------------------------------------------------
    logic [1:0] sel;
    logic       m_wr_lvl;
    logic       m_rd_lvl;
    logic       m_wr_prev_r;
    logic       m_wr;
    logic       m_rd;

    // Select lines form the address; strobes count only while selected
    assign sel      = {REG_SEL_HI_I, REG_SEL_LO_I};                 // [R17] [R5]
    assign m_wr_lvl = !SELECT_N_I && !WRITE_STROBE_N_I;             // [R15] [R16]
    assign m_rd_lvl = !SELECT_N_I && !READ_STROBE_N_I;              // [R15] [R16]
    // A long strobe must store once, so act on its leading edge
    assign m_wr     = m_wr_lvl && !m_wr_prev_r;
    assign m_rd     = m_rd_lvl;

    // Strobe history for edge detection
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            m_wr_prev_r <= 1'b0;
        end else begin
            m_wr_prev_r <= m_wr_lvl;
        end
    end

    // ----------------------------------------------------------------
    // Registers written by the master
    // ----------------------------------------------------------------
    logic [7:0] cmd_r;
    logic [7:0] chan_r;
    logic [7:0] din_r;

    // Write-side copies of addresses 0..2
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            cmd_r  <= SPCI_BYTE_RST;
            chan_r <= SPCI_BYTE_RST;
            din_r  <= SPCI_BYTE_RST;
        end else if (m_wr) begin
            if (sel == SPCI_SEL_CMD) begin
                cmd_r <= DATA_I;                                    // [R7] [R6]
            end
            if (sel == SPCI_SEL_CHAN) begin
                chan_r <= DATA_I;                                   // [R8] [R18]
            end
            if (sel == SPCI_SEL_DATA) begin
                din_r <= DATA_I;                                    // [R9] [R6]
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers written by the slave
    // ----------------------------------------------------------------
    logic [7:0] resp_r;
    logic [7:0] dout_r;
    logic       s_wr_resp;
    logic       s_wr_data;

    assign s_wr_resp = SLV_WR_I && (SLV_ADDR_I == SPCI_LOC_CMD);
    assign s_wr_data = SLV_WR_I && (SLV_ADDR_I == SPCI_LOC_DATA);

    // Read-side copies, kept apart from the master's writes
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            resp_r <= SPCI_BYTE_RST;
            dout_r <= SPCI_BYTE_RST;
        end else begin
            if (s_wr_resp) begin
                resp_r <= SLV_WDATA_I;                              // [R3] [R6]
            end
            if (s_wr_data) begin
                dout_r <= SLV_WDATA_I;                              // [R9]
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    logic [3:0] flag_r;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic       s_rd_cmd;
    logic       s_rd_chan;
    logic       s_rd_data;

    assign s_rd_cmd  = SLV_RD_I && (SLV_ADDR_I == SPCI_LOC_CMD);
    assign s_rd_chan = SLV_RD_I && (SLV_ADDR_I == SPCI_LOC_CHAN);
    assign s_rd_data = SLV_RD_I && (SLV_ADDR_I == SPCI_LOC_DATA);

    assign flag_set[SPCI_ST_CMD]  = m_wr && (sel == SPCI_SEL_CMD);   // [R19]
    assign flag_set[SPCI_ST_CHAN] = m_wr && (sel == SPCI_SEL_CHAN);
    assign flag_set[SPCI_ST_DATA] = m_wr && (sel == SPCI_SEL_DATA);
    assign flag_set[SPCI_ST_RESP] = s_wr_resp;                       // [R11]
    assign flag_clr[SPCI_ST_CMD]  = s_rd_cmd;                        // [R22]
    assign flag_clr[SPCI_ST_CHAN] = s_rd_chan;
    assign flag_clr[SPCI_ST_DATA] = s_rd_data;
    assign flag_clr[SPCI_ST_RESP] = m_wr && (sel == SPCI_SEL_STATUS); // [R12]

    // Set wins over clear so no event is lost in a collision
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= flag_set | (flag_r & ~flag_clr);               // [R22] [R13]
        end
    end

    // Command event pulse for interrupt-driven slave logic
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            CMD_EVENT_O <= 1'b0;
        end else begin
            CMD_EVENT_O <= flag_set[SPCI_ST_CMD];                    // [R19] [R1]
        end
    end

    assign CMD_PENDING_O     = flag_r[SPCI_ST_CMD];                  // [R19]
    assign CHAN_PENDING_O    = flag_r[SPCI_ST_CHAN];
    assign DATA_PENDING_O    = flag_r[SPCI_ST_DATA];
    // Attention follows the response flag, low while set
    assign ATTENTION_OUT_N_O = !flag_r[SPCI_ST_RESP];                // [R3] [R13]

    // ----------------------------------------------------------------
    // Read paths
    // ----------------------------------------------------------------
    logic [7:0] m_rdata;
    logic [7:0] s_rdata;

    // Master read mux
    always_comb begin
        case (sel)
            SPCI_SEL_CMD:    m_rdata = resp_r;                       // [R7]
            SPCI_SEL_CHAN:   m_rdata = SPCI_UNUSED_RD;               // [R8]
            SPCI_SEL_DATA:   m_rdata = dout_r;                       // [R9]
            SPCI_SEL_STATUS: m_rdata = {4'h0, flag_r};               // [R10]
            default:         m_rdata = SPCI_UNUSED_RD;
        endcase
    end

    // Slave read mux, seeing the master's written bytes
    always_comb begin
        case (SLV_ADDR_I)
            SPCI_LOC_CMD:    s_rdata = cmd_r;
            SPCI_LOC_CHAN:   s_rdata = chan_r;                       // [R18]
            SPCI_LOC_DATA:   s_rdata = din_r;
            SPCI_LOC_STATUS: s_rdata = {4'h0, flag_r};
            default:         s_rdata = SPCI_BYTE_RST;
        endcase
    end

    // Registered data outputs; bus enable tracks the selected read
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            DATA_O      <= SPCI_BYTE_RST;
            SLV_RDATA_O <= SPCI_BYTE_RST;
        end else begin
            DATA_O      <= m_rdata;
            SLV_RDATA_O <= s_rdata;
        end
    end

    // Driven only during a selected read; released otherwise
    assign DATA_OE_N_O = !m_rd;                                      // [R21]

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_resp_sets_flag: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R11]
        s_wr_resp |=> flag_r[SPCI_ST_RESP])
        else $error("Response write did not set status bit 3");

    a_status_clears: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R12]
        (flag_clr[SPCI_ST_RESP] && !s_wr_resp) |=> !flag_r[SPCI_ST_RESP])
        else $error("Status write did not clear bit 3");

    a_attn_holds: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R13]
        (!ATTENTION_OUT_N_O && !flag_clr[SPCI_ST_RESP]) |=> !ATTENTION_OUT_N_O)
        else $error("Attention released without status write");

    a_attn_rises: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R3]
        $fell(ATTENTION_OUT_N_O) |-> $past(s_wr_resp))
        else $error("Attention asserted without response write");

    a_bus_release: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R21]
        (SELECT_N_I || READ_STROBE_N_I) |-> DATA_OE_N_O)
        else $error("Data bus driven outside a selected read");

    a_cmd_store: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R7]
        flag_set[SPCI_ST_CMD] |=> (cmd_r == $past(DATA_I)) && CMD_EVENT_O)
        else $error("Command byte not stored or event missing");

    a_chan_store: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R18]
        flag_set[SPCI_ST_CHAN] |=> chan_r == $past(DATA_I))
        else $error("Channel byte not stored");

    a_no_unselected: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R15]
        SELECT_N_I |=> $stable(cmd_r) && $stable(chan_r) && $stable(din_r))
        else $error("Write taken while not selected");

    a_status_read: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R10]
        (m_rd && sel == SPCI_SEL_STATUS) |=> DATA_O == {4'h0, $past(flag_r)})
        else $error("Status read value wrong");

    a_flag_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R22]
        (s_rd_chan && !flag_set[SPCI_ST_CHAN]) |=> !CHAN_PENDING_O)
        else $error("Channel flag not cleared by slave read");

    // Slave-written bytes must land in the read-side copies
    a_resp_store: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R3] [R6]
        s_wr_resp |=> resp_r == $past(SLV_WDATA_I))
        else $error("Response byte not stored");

    a_dout_store: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R9]
        s_wr_data |=> dout_r == $past(SLV_WDATA_I))
        else $error("Returned data byte not stored");

    a_data_store: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R9] [R6]
        flag_set[SPCI_ST_DATA] |=> din_r == $past(DATA_I))
        else $error("Master data byte not stored");

    // A held strobe must not store a second time
    a_long_strobe: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R16]
        (m_wr_lvl && m_wr_prev_r) |=> $stable(cmd_r) && $stable(chan_r) && $stable(din_r))
        else $error("Held write strobe stored twice");

    // One event per command, and the poll flag never rises alone
    a_event_once: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R1]
        CMD_EVENT_O |=> !CMD_EVENT_O)
        else $error("Command event longer than one cycle");

    a_event_cause: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R19]
        $rose(CMD_PENDING_O) |-> CMD_EVENT_O)
        else $error("Poll flag rose without command event");

    // Master reads see the slave-side copies, not the written bytes
    a_resp_read: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R7] [R6]
        (m_rd && sel == SPCI_SEL_CMD) |=> DATA_O == $past(resp_r))
        else $error("Response read value wrong");

    a_unused_read: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R8]
        (m_rd && sel == SPCI_SEL_CHAN) |=> DATA_O == SPCI_UNUSED_RD)
        else $error("Unused address read not zero");

    a_bus_drive: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R21]
        (!SELECT_N_I && !READ_STROBE_N_I) |-> !DATA_OE_N_O)
        else $error("Data bus not driven in selected read");

    a_slave_chan_read: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R18]
        s_rd_chan |=> SLV_RDATA_O == $past(chan_r))
        else $error("Slave channel read value wrong");

    a_data_flag: assert property (@(posedge CLOCK_I) disable iff (RST_I) // [R22]
        flag_set[SPCI_ST_DATA] |=> DATA_PENDING_O)
        else $error("Data flag not set by master write");

endmodule

// ===== verif/spci_master_model.sv
// Master controller model for the parallel slave port
`timescale 1ns/1ps
module spci_master_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] bus_i,
    output logic            select_n_o,
    output logic            write_strobe_n_o,
    output logic            read_strobe_n_o,
    output logic      [1:0] reg_sel_o,
    output logic      [7:0] bus_o
);
    // Idle: deselected, both strobes high
    initial begin
        select_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        reg_sel_o = 2'h0;
        bus_o = 8'h00;
    end

    // One write cycle, always master-started; sel_v high gives a deselected strobe
    task automatic bus_write(input logic [1:0] a, input logic [7:0] d, input logic sel_v);
        @(negedge clk_i);
        select_n_o = sel_v;
        reg_sel_o = a;
        bus_o = d;
        write_strobe_n_o = 1'b0;
        @(negedge clk_i);
        select_n_o = 1'b1;
        write_strobe_n_o = 1'b1; // High gap before next write
        bus_o = ~d; // Released bus must not show a stale byte
    endtask

    // One read cycle; data is registered, so sample a cycle later
    task automatic bus_read(input logic [1:0] a, output logic [7:0] d);
        @(negedge clk_i);
        select_n_o = 1'b0;
        reg_sel_o = a;
        read_strobe_n_o = 1'b0;
        @(negedge clk_i);
        d = bus_i;
        select_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
    endtask
endmodule

// ===== verif/tb.sv
// Self-checking testbench for the slave port command interface
`timescale 1ns/1ps
module tb;
    import spci_pkg::*;
    logic       clk, rst, slv_rd, slv_wr, oe_n, attn_n, cmd_event;
    logic       cmd_pend, chan_pend, data_pend, sel_n, wr_n, rd_n;
    logic [1:0] reg_sel;
    logic [7:0] slv_addr, slv_wdata, data_o, slv_rdata, rd_v, m_bus;
    wire  [7:0] data_bus;
    int         err_total, samples_checked;

    // Bus level: device drives only while its enable is low
    assign data_bus = !oe_n ? data_o : m_bus;

    spci_port spci_port_inst (.CLOCK_I(clk), .RST_I(rst), .SELECT_N_I(sel_n),
        .WRITE_STROBE_N_I(wr_n), .READ_STROBE_N_I(rd_n), .REG_SEL_LO_I(reg_sel[0]),
        .REG_SEL_HI_I(reg_sel[1]), .DATA_I(data_bus), .DATA_O(data_o), .DATA_OE_N_O(oe_n),
        .ATTENTION_OUT_N_O(attn_n), .SLV_RD_I(slv_rd), .SLV_ADDR_I(slv_addr),
        .SLV_RDATA_O(slv_rdata), .SLV_WR_I(slv_wr), .SLV_WDATA_I(slv_wdata),
        .CMD_EVENT_O(cmd_event), .CMD_PENDING_O(cmd_pend), .CHAN_PENDING_O(chan_pend),
        .DATA_PENDING_O(data_pend));

    spci_master_model m (.clk_i(clk), .bus_i(data_bus), .select_n_o(sel_n),
        .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .reg_sel_o(reg_sel), .bus_o(m_bus));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Compare one value and count it
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Slave-side accesses, one strobe cycle each
    task automatic slv_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        slv_rd = 1'b1;
        slv_addr = a;
        @(negedge clk);
        slv_rd = 1'b0;
        check("slave read", slv_rdata, exp);
    endtask

    task automatic slv_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        slv_wr = 1'b1;
        slv_addr = a;
        slv_wdata = d;
        @(negedge clk);
        slv_wr = 1'b0;
    endtask

    // Master read with expected value
    task automatic mread(input logic [1:0] a, input logic [7:0] exp);
        m.bus_read(a, rd_v);
        check("master read", rd_v, exp);
    endtask

    // Idle state after reset
    task automatic reset_check();
        check("attention", {7'h0, attn_n}, 8'h01);
        check("bus enable", {7'h0, oe_n}, 8'h01);
        mread(SPCI_SEL_STATUS, 8'h00);
    endtask

    // Full command, response and release sequence
    task automatic command_flow();
        m.bus_write(SPCI_SEL_CHAN, 8'hFF, 1'b0);
        m.bus_write(SPCI_SEL_DATA, 8'hA5, 1'b0);
        m.bus_write(SPCI_SEL_CMD, 8'h3C, 1'b0);
        check("event", {7'h0, cmd_event}, 8'h01);
        @(negedge clk);
        check("event", {7'h0, cmd_event}, 8'h00);
        check("pending", {5'h0, data_pend, chan_pend, cmd_pend}, 8'h07);
        mread(SPCI_SEL_STATUS, 8'h07);
        slv_read(SPCI_LOC_CHAN, 8'hFF);
        slv_read(SPCI_LOC_DATA, 8'hA5);
        slv_read(SPCI_LOC_CMD, 8'h3C);
        check("pending", {5'h0, data_pend, chan_pend, cmd_pend}, 8'h00);
        slv_write(SPCI_LOC_DATA, 8'h5A);
        slv_write(SPCI_LOC_CMD, 8'h81);
        check("attention", {7'h0, attn_n}, 8'h00);
        slv_read(SPCI_LOC_STATUS, 8'h08);
        mread(SPCI_SEL_STATUS, 8'h08);
        mread(SPCI_SEL_CMD, 8'h81);
        mread(SPCI_SEL_DATA, 8'h5A);
        mread(SPCI_SEL_CHAN, SPCI_UNUSED_RD);
        m.bus_write(SPCI_SEL_STATUS, 8'h00, 1'b1);
        check("attention", {7'h0, attn_n}, 8'h00);
        m.bus_write(SPCI_SEL_STATUS, 8'h5A, 1'b0);
        check("attention", {7'h0, attn_n}, 8'h01);
        mread(SPCI_SEL_STATUS, 8'h00);
        @(negedge clk);
        check("bus enable", {7'h0, oe_n}, 8'h01);
    endtask

    // Main sequence: reset held for six cycles
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        slv_rd = 1'b0;
        slv_wr = 1'b0;
        slv_addr = 8'h00;
        slv_wdata = 8'h00;
        err_total = 0;
        samples_checked = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        reset_check();
        command_flow();
        stop_test();
    end

    // Watchdog: the tests need well under 200 cycles
    initial begin
        #(2000 * 50);
        err_total++;
        stop_test();
    end
endmodule
